// File: verilog/isn_slave.sv
// two-wire sensor node slave with message framing and data buffer
// What this block does
// - bytes move eight bits, most significant first; master starts every transfer.
// - ninth clock per byte; transmitter releases SDA, receiver drives acknowledge.
// - receiver pulls SDA low to acknowledge, leaves it high to refuse.
// - receiver refuses after the last byte it wants, ending the transfer.
// - SDA changes only while SCL is low, except start and stop.
// - SDA falling with SCL high is start; address byte follows.
// - SDA rising with SCL high is stop; slave detects it.
// - stop returns the slave state machine to idle.
// - repeated start counts as new start expecting a fresh address.
// - first byte holds seven-bit address high, bit zero one means read.
// - acknowledge address only on own address match, else release SDA.
// - acknowledge every received byte of a master write except the closing checksum byte.
// - refuse after the last accepted byte so master stops sending.
// - on read, hold SCL low until transmit byte ready, then release.
// - when transmitting, release SDA on ninth clock, latch master acknowledge.
// - master acknowledge means prepare next transmit byte.
// - master refusal ends transfer; wait for next start.
// - each message carries a start offset and a byte count.
// - received data checked by checksum; a mismatch sets the checksum-fail status bit.
// - master sends only write messages or request messages.
// - length byte low seven bits count, top bit set means request.
// - byte after length gives the buffer start offset.
// - message ends with eight-bit two's-complement sum over all bytes.
// - status byte is always the first byte returned on a read.
`timescale 1ns/1ps
module isn_slave #(
	parameter logic [6:0] OWN_ADDR = isn_pkg::OWN_ADDR_DEF,
	parameter int BUF_DEPTH = isn_pkg::BUF_DEPTH_DEF,
	parameter int AW = $clog2(BUF_DEPTH)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic app_wr_en,
	input wire logic [AW-1:0] app_wr_addr,
	input wire logic [7:0] app_wr_data,
	input wire logic [AW-1:0] app_rd_addr,
	output logic [7:0] app_rd_data,
	input wire logic lnk_clk,
	input wire logic lnk_tx_ready,
	output logic lnk_msg_pulse,
	output logic [7:0] lnk_msg_stat
);
	function automatic logic in_buf(input logic [7:0] a);
		in_buf = {1'b0, a} < 9'(BUF_DEPTH);
	endfunction

	function automatic logic [7:0] mk_stat(input logic rw, input logic ovf, input logic rxe,
		input logic chk);
		mk_stat = 8'h00;
		mk_stat[isn_pkg::ST_RW] = rw;
		mk_stat[isn_pkg::ST_OVFLW] = ovf;
		mk_stat[isn_pkg::ST_RXERR] = rxe;
		mk_stat[isn_pkg::ST_CHKFAIL] = chk;
	endfunction

	logic [7:0] mem [BUF_DEPTH];
	isn_pkg::isn_state_e state_r, state_nxt;
	logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, rdy_m, rdy_s;
	logic [3:0] bitc_r, bitc_nxt;
	logic [7:0] sh_r, sh_nxt, off_r, off_nxt, sum_r, sum_nxt, stat_r, stat_nxt;
	logic [7:0] txk_r, txk_nxt;
	logic [6:0] len_r, len_nxt, cnt_r, cnt_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic req_r, req_nxt, ovf_r, ovf_nxt, open_r, open_nxt, rnw_r, rnw_nxt;
	logic ack_r, ack_nxt, mack_r, mack_nxt, tog_r, tog_nxt;
	logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
	logic [15:0] tcs_r, tcs_nxt;
	logic lk_m, lk_s, lk_q, lnk_pulse_r;
	logic [7:0] lnk_stat_r, app_rd_r;

	// edges from synchronised samples only
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
	wire byte_end = (state_r == isn_pkg::ST_RX) && scl_fall && (bitc_r == isn_pkg::BITS_BYTE);
	wire is_addr = idx_r == isn_pkg::IDX_ADDR;
	wire addr_hit = sh_r[7:1] == OWN_ADDR;
	wire in_data = idx_r == isn_pkg::IDX_DATA;
	wire is_wdat = in_data && !req_r && (cnt_r != len_r);
	wire is_chk = in_data && !is_wdat;
	wire do_ack = is_addr ? addr_hit : !is_chk;
	wire [7:0] sum_add = sum_r + sh_r;
	wire [7:0] wr_idx = off_r + {1'b0, cnt_r};
	wire bus_we = byte_end && is_wdat && in_buf(wr_idx);
	wire [8:0] end_pos = {1'b0, sh_r} + {2'b00, len_r};
	wire [6:0] nlen = stat_r[isn_pkg::ST_RW] ? len_r : 7'h00;
	wire [7:0] rd_idx = off_r + txk_r - 8'h01;
	wire [15:0] csum = 16'h0000 - tcs_r;
	wire tx_dat = (txk_r != 8'h00) && (txk_r <= {1'b0, nlen});
	wire tx_sum = txk_r <= {1'b0, nlen};
	wire [7:0] mem_byte = in_buf(rd_idx) ? mem[rd_idx[AW-1:0]] : isn_pkg::FILL_BYTE;
	wire [7:0] tx_byte = (txk_r == 8'h00) ? stat_r :
		tx_dat ? mem_byte :
		(txk_r == {1'b0, nlen} + 8'h01) ? csum[15:8] :
		(txk_r == {1'b0, nlen} + 8'h02) ? csum[7:0] : isn_pkg::FILL_BYTE;

	always_comb begin
		state_nxt = state_r;
		bitc_nxt = bitc_r;
		sh_nxt = sh_r;
		off_nxt = off_r;
		sum_nxt = sum_r;
		stat_nxt = stat_r;
		txk_nxt = txk_r;
		len_nxt = len_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		req_nxt = req_r;
		ovf_nxt = ovf_r;
		open_nxt = open_r;
		rnw_nxt = rnw_r;
		ack_nxt = ack_r;
		mack_nxt = mack_r;
		tog_nxt = tog_r;
		sda_oe_nxt = sda_oe_r;
		scl_oe_nxt = scl_oe_r;
		tcs_nxt = tcs_r;
		if (start_det || stop_det) begin
			// unfinished message is flagged, never silently dropped
			if (open_r) begin
				open_nxt = 1'b0;
				stat_nxt = mk_stat(req_r, ovf_r, 1'b1, 1'b0);
			end
			state_nxt = start_det ? isn_pkg::ST_RX : isn_pkg::ST_IDLE;
			bitc_nxt = 4'h0;
			idx_nxt = isn_pkg::IDX_ADDR;
			rnw_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end else begin
			unique case (state_r)
				isn_pkg::ST_IDLE: begin
				end
				isn_pkg::ST_RX: begin
					if (scl_rise && bitc_r != isn_pkg::BITS_BYTE) begin
						sh_nxt = {sh_r[6:0], sda_s};
						bitc_nxt = bitc_r + 4'h1;
					end
					if (byte_end) begin
						state_nxt = isn_pkg::ST_RACK;
						ack_nxt = do_ack;
						sda_oe_nxt = do_ack;
						if (is_addr && addr_hit) begin
							rnw_nxt = sh_r[0];
							txk_nxt = 8'h00;
							tcs_nxt = 16'h0000;
							if (!sh_r[0]) begin
								open_nxt = 1'b1;
								idx_nxt = isn_pkg::IDX_LEN;
								sum_nxt = sh_r;
								cnt_nxt = 7'h00;
								ovf_nxt = 1'b0;
							end
						end else if (idx_r == isn_pkg::IDX_LEN) begin
							len_nxt = sh_r[6:0];
							req_nxt = sh_r[isn_pkg::LEN_REQ_BIT];
							sum_nxt = sum_add;
							idx_nxt = isn_pkg::IDX_OFFS;
						end else if (idx_r == isn_pkg::IDX_OFFS) begin
							off_nxt = sh_r;
							ovf_nxt = end_pos > 9'(BUF_DEPTH);
							sum_nxt = sum_add;
							idx_nxt = isn_pkg::IDX_DATA;
						end else if (is_wdat) begin
							cnt_nxt = cnt_r + 7'h01;
							sum_nxt = sum_add;
						end else if (is_chk) begin
							open_nxt = 1'b0;
							tog_nxt = ~tog_r;
							stat_nxt = mk_stat(req_r, ovf_r, 1'b0, sum_add != 8'h00);
						end
					end
				end
				isn_pkg::ST_RACK: begin
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						bitc_nxt = 4'h0;
						if (!ack_r) begin
							state_nxt = isn_pkg::ST_IDLE;
						end else if (rnw_r) begin
							state_nxt = isn_pkg::ST_HOLD;
							scl_oe_nxt = 1'b1;
						end else begin
							state_nxt = isn_pkg::ST_RX;
						end
					end
				end
				isn_pkg::ST_HOLD: begin
					if (rdy_s) begin
						state_nxt = isn_pkg::ST_TX;
						sh_nxt = tx_byte;
						sda_oe_nxt = !tx_byte[7];
						bitc_nxt = 4'h1;
						if (txk_r != isn_pkg::TXK_MAX) begin
							txk_nxt = txk_r + 8'h01;
						end
						if (tx_sum) begin
							tcs_nxt = tcs_r + {8'h00, tx_byte};
						end
					end
				end
				isn_pkg::ST_TX: begin
					// scl freed one cycle after the first bit is on sda
					scl_oe_nxt = 1'b0;
					if (scl_fall) begin
						if (bitc_r == isn_pkg::BITS_BYTE) begin
							sda_oe_nxt = 1'b0;
							state_nxt = isn_pkg::ST_TACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							sda_oe_nxt = !sh_r[6];
							bitc_nxt = bitc_r + 4'h1;
						end
					end
				end
				isn_pkg::ST_TACK: begin
					if (scl_rise) begin
						mack_nxt = sda_s;
					end
					if (scl_fall) begin
						if (!mack_r) begin
							state_nxt = isn_pkg::ST_HOLD;
							scl_oe_nxt = 1'b1;
						end else begin
							state_nxt = isn_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_nxt = isn_pkg::ST_IDLE;
					sda_oe_nxt = 1'b0;
					scl_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3F;
			{rdy_m, rdy_s} <= 2'h0;
		end else begin
			// first stage feeds only the second
			{scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
			{rdy_m, rdy_s} <= {lnk_tx_ready, rdy_m};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= isn_pkg::ST_IDLE;
			{bitc_r, idx_r, len_r, cnt_r} <= 20'h00000;
			{sh_r, off_r, sum_r, txk_r} <= 32'h00000000;
			stat_r <= isn_pkg::STAT_RST;
			{req_r, ovf_r, open_r, rnw_r, ack_r, mack_r, tog_r} <= 7'h00;
			{sda_oe_r, scl_oe_r} <= 2'h0;
			tcs_r <= 16'h0000;
			app_rd_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			{bitc_r, idx_r, len_r, cnt_r} <= {bitc_nxt, idx_nxt, len_nxt, cnt_nxt};
			{sh_r, off_r, sum_r, txk_r} <= {sh_nxt, off_nxt, sum_nxt, txk_nxt};
			stat_r <= stat_nxt;
			{req_r, ovf_r, open_r, rnw_r} <= {req_nxt, ovf_nxt, open_nxt, rnw_nxt};
			{ack_r, mack_r, tog_r} <= {ack_nxt, mack_nxt, tog_nxt};
			{sda_oe_r, scl_oe_r} <= {sda_oe_nxt, scl_oe_nxt};
			tcs_r <= tcs_nxt;
			app_rd_r <= mem[app_rd_addr];
		end
	end

	// bus writes win over the application port
	always_ff @(posedge core_clk) begin
		if (bus_we) begin
			mem[wr_idx[AW-1:0]] <= sh_r;
		end else if (app_wr_en) begin
			mem[app_wr_addr] <= app_wr_data;
		end
	end

	// message-done event to the application clock; status is stable by then
	always_ff @(posedge lnk_clk or negedge rst_n) begin
		if (!rst_n) begin
			{lk_m, lk_s, lk_q, lnk_pulse_r} <= 4'h0;
			lnk_stat_r <= isn_pkg::STAT_RST;
		end else begin
			{lk_m, lk_s, lk_q} <= {tog_r, lk_m, lk_s};
			lnk_pulse_r <= lk_s ^ lk_q;
			if (lk_s ^ lk_q) begin
				lnk_stat_r <= stat_r;
			end
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign app_rd_data = app_rd_r;
	assign lnk_msg_pulse = lnk_pulse_r;
	assign lnk_msg_stat = lnk_stat_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_byte_end;
		byte_end;
	endsequence
	sequence s_ninth_fall;
		state_r == isn_pkg::ST_RACK && scl_fall;
	endsequence

	sequence s_tx_launch;
		state_r == isn_pkg::ST_HOLD && rdy_s && !start_det && !stop_det;
	endsequence
	sequence s_quiet_rise;
		scl_rise && !start_det && !stop_det;
	endsequence

	AST_START_RX: assert property (start_det
		|=> state_r == isn_pkg::ST_RX && bitc_r == 4'h0)
		else $error("start not taken");
	AST_STOP_IDLE: assert property (stop_det
		|=> state_r == isn_pkg::ST_IDLE && !sda_oe_r && !scl_oe_r)
		else $error("stop did not idle");
	AST_SDA_STEADY: assert property (scl_s && scl_q && !start_det && !stop_det
		|=> $stable(sda_oe_r))
		else $error("sda moved with scl high");
	AST_ADDR_MISS: assert property (s_byte_end ##0 (is_addr && !addr_hit)
		|=> !sda_oe_r ##1 !sda_oe_r)
		else $error("foreign address acknowledged");
	AST_ADDR_ACK: assert property (s_byte_end ##0 (is_addr && addr_hit)
		|=> sda_oe_r && state_r == isn_pkg::ST_RACK)
		else $error("own address not acknowledged");
	AST_DATA_ACK: assert property (s_byte_end ##0 is_wdat |=> sda_oe_r [*1] ##0 ack_r)
		else $error("write data not acknowledged");
	AST_CHK_NACK: assert property (s_byte_end ##0 is_chk
		|=> !sda_oe_r && tog_r != $past(tog_r))
		else $error("checksum byte handled wrong");
	AST_STRETCH: assert property (s_ninth_fall ##0 (ack_r && rnw_r)
		|=> scl_oe_r && state_r == isn_pkg::ST_HOLD)
		else $error("no stretch before transmit");
	AST_TX_RELEASE: assert property (state_r == isn_pkg::ST_TX && scl_fall
		&& bitc_r == isn_pkg::BITS_BYTE |=> !sda_oe_r && state_r == isn_pkg::ST_TACK)
		else $error("sda held on ninth clock");
	AST_MASTER_NACK: assert property (state_r == isn_pkg::ST_TACK && scl_fall && mack_r
		&& !start_det && !stop_det |=> state_r == isn_pkg::ST_IDLE && !scl_oe_r)
		else $error("transfer not ended on refusal");
	AST_STATUS_FIRST: assert property (s_tx_launch ##0 txk_r == 8'h00
		|=> sh_r == stat_r && sda_oe_r == !stat_r[7])
		else $error("status byte not first");
	AST_LNK_PULSE: assert property (@(posedge lnk_clk) disable iff (!rst_n)
		lnk_pulse_r |=> !lnk_pulse_r)
		else $error("message pulse too long");
	AST_SCL_AFTER_SDA: assert property (s_tx_launch |=> scl_oe_r ##1 !scl_oe_r)
		else $error("scl freed before first bit set");
	AST_RX_SHIFT: assert property (s_quiet_rise ##0 (state_r == isn_pkg::ST_RX
		&& bitc_r != isn_pkg::BITS_BYTE) |=> sh_r[0] == $past(sda_s))
		else $error("received bit not shifted in");
	AST_MACK_LATCH: assert property (s_quiet_rise ##0 state_r == isn_pkg::ST_TACK
		|=> mack_r == $past(sda_s))
		else $error("master acknowledge not latched");
	AST_REFUSE_IDLE: assert property (s_ninth_fall ##0 !ack_r
		|=> state_r == isn_pkg::ST_IDLE && !sda_oe_r)
		else $error("refused byte did not end transfer");
	AST_CUT_FLAG: assert property ((start_det || stop_det) && open_r
		|=> stat_r[isn_pkg::ST_RXERR] && !open_r)
		else $error("cut message not flagged");
	AST_OVF_STATUS: assert property (s_byte_end ##0 is_chk
		|=> stat_r[isn_pkg::ST_OVFLW] == $past(ovf_r))
		else $error("overflow not reported");
endmodule

// File: verilog/isn_pkg.sv
// shared constants and types for the sensor node two-wire slave
package isn_pkg;
	localparam logic [6:0] OWN_ADDR_DEF = 7'h2A;
	localparam int BUF_DEPTH_DEF = 64;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [1:0] IDX_ADDR = 2'h0;
	localparam logic [1:0] IDX_LEN = 2'h1;
	localparam logic [1:0] IDX_OFFS = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;
	localparam int LEN_REQ_BIT = 7;
	localparam int ST_CHKFAIL = 0;
	localparam int ST_RXERR = 1;
	localparam int ST_OVFLW = 2;
	localparam int ST_RW = 7;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [7:0] TXK_MAX = 8'hFF;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_RACK = 6'h04,
		ST_HOLD = 6'h08,
		ST_TX = 6'h10,
		ST_TACK = 6'h20
	} isn_state_e;
endpackage

// File: verif/isn_mst_model.sv
// two-wire bus master model facing the sensor node slave
`timescale 1ns/1ps
module isn_mst_model (
	input wire logic core_clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_pull,
	output logic sda_pull
);
	localparam int QTR = 8;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	task automatic qwait();
		repeat (QTR) @(negedge core_clk);
	endtask
	// release scl, then wait out stretching by the slave for up to 400 clocks
	task automatic rise_scl();
		scl_pull = 1'b0;
		for (int i = 0; i < 400 && scl !== 1'b1; i++) @(negedge core_clk);
		qwait();
	endtask
	task automatic start();
		sda_pull = 1'b0;
		qwait();
		rise_scl();
		sda_pull = 1'b1;
		qwait();
		scl_pull = 1'b1;
		qwait();
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		qwait();
		rise_scl();
		sda_pull = 1'b0;
		qwait();
	endtask
	// sda moves only while scl is low
	task automatic bit_x(input logic b, output logic r);
		sda_pull = ~b;
		qwait();
		rise_scl();
		r = sda;
		qwait();
		scl_pull = 1'b1;
		qwait();
	endtask
	task automatic byte_wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	task automatic byte_rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(~ack, r);
	endtask
endmodule

// File: verif/tb.sv
// self-checking bench for the sensor node two-wire slave
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
	logic core_clk = 1'b0;
	logic lnk_clk = 1'b0;
	logic rst_n = 1'b0;
	logic app_wr_en = 1'b0;
	logic [5:0] app_wr_addr = 6'h00;
	logic [7:0] app_wr_data = 8'h00;
	logic [5:0] app_rd_addr = 6'h00;
	logic lnk_tx_ready = 1'b1;
	logic scl_o, scl_oe, sda_o, sda_oe, mst_scl, mst_sda, lnk_msg_pulse;
	logic [7:0] app_rd_data, lnk_msg_stat;
	logic [7:0] last_stat = 8'h00;
	logic [7:0] dat [0:1] = '{8'hA5, 8'h3C};
	wire logic scl_w, sda_w;
	int mismatches = 0;
	int checks_done = 0;
	int pulses = 0;
	always #2.5 core_clk = ~core_clk;
	initial begin
		#1.7;
		forever #6 lnk_clk = ~lnk_clk;
	end
	// open-drain wires with pull-ups
	assign scl_w = ~(mst_scl | (scl_oe & ~scl_o));
	assign sda_w = ~(mst_sda | (sda_oe & ~sda_o));
	isn_slave isn_slave_i (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .app_wr_en(app_wr_en),
		.app_wr_addr(app_wr_addr), .app_wr_data(app_wr_data), .app_rd_addr(app_rd_addr),
		.app_rd_data(app_rd_data), .lnk_clk(lnk_clk), .lnk_tx_ready(lnk_tx_ready),
		.lnk_msg_pulse(lnk_msg_pulse), .lnk_msg_stat(lnk_msg_stat));
	isn_mst_model isn_mst_model_i (.core_clk(core_clk), .scl(scl_w), .sda(sda_w),
		.scl_pull(mst_scl), .sda_pull(mst_sda));
	always @(posedge lnk_clk) begin
		if (lnk_msg_pulse === 1'b1) begin
			pulses <= pulses + 1;
			last_stat <= lnk_msg_stat;
		end
	end
	task automatic final_report();
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		isn_mst_model_i.byte_wr(b, a);
		`CHK("ack", exp_ack, a)
	endtask
	task automatic msg(input logic [7:0] len, input logic [7:0] offs, input logic [7:0] bad);
		logic [7:0] sum;
		sum = 8'h54 + len + offs;
		isn_mst_model_i.start();
		send(8'h54, 1'b1);
		send(len, 1'b1);
		send(offs, 1'b1);
		for (int i = 0; i < len[6:0] && !len[7]; i++) begin
			send(dat[i], 1'b1);
			sum = sum + dat[i];
		end
		send((~sum + 8'h01) ^ bad, 1'b0);
		isn_mst_model_i.stop();
	endtask
	task automatic wait_pulse(input int n, input logic [7:0] st);
		for (int i = 0; i < 40 && pulses != n; i++) @(negedge lnk_clk);
		`CHK("pulses", n, pulses)
		`CHK("msg_stat", st, last_stat)
	endtask
	task automatic mem_chk(input logic [5:0] a, input logic [7:0] ex);
		@(negedge core_clk) app_rd_addr = a;
		repeat (2) @(negedge core_clk);
		`CHK("mem", ex, app_rd_data)
	endtask
	task automatic rd_status(input logic [7:0] st, input logic last, input logic stall);
		logic [7:0] d;
		if (stall) @(negedge lnk_clk) lnk_tx_ready = 1'b0;
		isn_mst_model_i.start();
		send(8'h55, 1'b1);
		if (stall) begin
			repeat (20) @(negedge core_clk);
			`CHK("stretch", 1'b1, scl_oe)
			@(negedge lnk_clk) lnk_tx_ready = 1'b1;
		end
		isn_mst_model_i.byte_rd(~last, d);
		`CHK("status", st, d)
	endtask
	task automatic t_write();
		msg(8'h02, 8'h05, 8'h00);
		wait_pulse(1, 8'h00);
		mem_chk(6'h05, dat[0]);
		mem_chk(6'h06, dat[1]);
	endtask
	task automatic t_foreign();
		isn_mst_model_i.start();
		send(8'h56, 1'b0);
		isn_mst_model_i.stop();
	endtask
	task automatic t_badsum();
		msg(8'h02, 8'h05, 8'h01);
		wait_pulse(2, 8'h01);
	endtask
	task automatic t_request();
		logic [7:0] d;
		logic [15:0] cs;
		cs = 16'h0000 - (16'h0080 + dat[0] + dat[1]);
		msg(8'h82, 8'h05, 8'h00);
		wait_pulse(3, 8'h80);
		rd_status(8'h80, 1'b0, 1'b1);
		for (int i = 0; i < 2; i++) begin
			isn_mst_model_i.byte_rd(1'b1, d);
			`CHK("rd_data", dat[i], d)
		end
		isn_mst_model_i.byte_rd(1'b1, d);
		`CHK("rd_sum_hi", cs[15:8], d)
		isn_mst_model_i.byte_rd(1'b0, d);
		`CHK("rd_sum_lo", cs[7:0], d)
		isn_mst_model_i.stop();
	endtask
	task automatic t_cut();
		@(negedge core_clk);
		app_wr_en = 1'b1;
		app_wr_addr = 6'h09;
		app_wr_data = 8'h77;
		@(negedge core_clk) app_wr_en = 1'b0;
		mem_chk(6'h09, 8'h77);
		isn_mst_model_i.start();
		send(8'h54, 1'b1);
		send(8'h01, 1'b1);
		isn_mst_model_i.stop();
		rd_status(8'h02, 1'b1, 1'b0);
		isn_mst_model_i.stop();
		`CHK("no_pulse", 3, pulses)
	endtask
	task automatic t_ovflw();
		@(negedge core_clk);
		app_wr_en = 1'b1;
		app_wr_addr = 6'h00;
		app_wr_data = 8'h11;
		@(negedge core_clk) app_wr_en = 1'b0;
		msg(8'h02, 8'h3F, 8'h00);
		wait_pulse(4, 8'h04);
		mem_chk(6'h3F, dat[0]);
		mem_chk(6'h00, 8'h11);
		`CHK("pin_levels", 2'h0, {scl_o, sda_o})
	endtask
	initial begin
		#400000;
		mismatches++;
		final_report();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge core_clk);
		t_write();
		t_foreign();
		t_badsum();
		t_request();
		t_cut();
		t_ovflw();
		final_report();
	end
endmodule
